// [design/adc_clk_pkg.sv]
package adc_clk_pkg;

  // correction sequencer states
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_RD_OFF  = 5'b00010,
    ST_RD_GAIN = 5'b00100,
    ST_CALC    = 5'b01000,
    ST_DONE    = 5'b10000
  } corr_state_t;

endpackage : adc_clk_pkg

// [design/adc_clk_regs.svh]
`ifndef ADC_CLK_REGS_SVH
`define ADC_CLK_REGS_SVH

// register byte offsets and calibration/result page numbers
`define CFG_OFS        12'h000
`define STAT_OFS       12'h004
`define IRQ_EN_OFS     12'h008
`define IRQ_CLR_OFS    12'h00c
`define DIV_STATE_OFS  12'h010
`define OFS_CORR_PAGE  8'h02
`define GAIN_CORR_PAGE 8'h03
`define RESULT_PAGE    8'h04

// configuration field positions
`define CFG_PRE_LSB    0
`define CFG_PRE_MSB    1
`define CFG_RATIO_LSB  2
`define CFG_RATIO_MSB  4
`define CFG_EXT_BIT    5

// status and interrupt bit positions
`define ST_READY_BIT   0
`define ST_SAT_BIT     1

// reset values
`define PRE_RST        2'h0
`define RATIO_RST      3'h3
`define EXT_RST        1'h1
`define IRQ_EN_RST     2'h0

// divider figures
`define SAMPLE_DIV_LAST 2'h3
`define RATIO_BASE      13'h0020

`endif

// [design/adc_clock_rate_divider.sv]
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "adc_clk_regs.svh"

module adc_clock_rate_divider
  import adc_clk_pkg::*;
#(
  parameter int CH      = 3,
  parameter int CAL_W   = 24,
  parameter int RATIO_W = 12,
  parameter int AW      = 12
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  input  wire logic                crystal_osc_tick,
  input  wire logic                oscillator_or_clock_input_pin,
  output logic                     oscillator_enable,
  input  wire logic [CH*CAL_W-1:0] raw_data,
  output logic                     analog_modulator_clock,
  output logic                     sampling_clock,
  output logic                     output_rate_clock,
  output logic                     result_ready_pulse,
  output logic      [CH*CAL_W-1:0] result_data,
  output logic                     irq
);

  // configuration and interrupt registers
  logic [1:0]         prescale_r;
  logic [2:0]         decimation_ratio_field_r;
  logic               external_clock_select_r;
  logic [1:0]         status_r;
  logic [1:0]         irq_en_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [31:0]        prdata_r;
  logic               mem_pend_r;

  // divider chain
  logic [2:0]         pre_cnt_r;
  logic [1:0]         samp_cnt_r;
  logic [RATIO_W-1:0] rate_cnt_r;
  logic               master_tick;
  logic               mod_en;
  logic               samp_en;
  logic               rate_en;
  logic [2:0]         pre_last;
  logic [RATIO_W-1:0] rate_last;
  logic [RATIO_W:0]   ratio_full;

  // correction sequencer
  corr_state_t        state_r;
  logic [1:0]         ch_r;
  logic [CAL_W-1:0]   raw_r [CH];
  logic [CAL_W-1:0]   result_r [CH];
  logic signed [CAL_W:0]     sum_r;
  logic signed [CAL_W+1:0]   factor;
  logic signed [2*CAL_W+2:0] prod;
  logic signed [2*CAL_W+2:0] scaled;
  logic [CAL_W+3:0]   upper;
  logic               sat_hit;
  logic [CAL_W-1:0]   sat_val;

  // bus decode
  logic               access;
  logic               done;
  logic [7:0]         page;
  logic [1:0]         idx;
  logic               idx_ok;
  logic               is_cal;
  logic               is_res;
  logic               addr_ok;
  logic               wr_cfg;
  logic               wr_ien;
  logic               wr_clr;
  logic               mem_wr;
  logic               apb_mem_rd;
  logic               mem_rd;
  logic [2:0]         mem_rd_addr;
  logic [CAL_W-1:0]   mem_rd_data;
  logic [31:0]        rd_mux;
  logic [1:0]         ev_set;

  // master clock source choice and crystal enable
  assign master_tick = external_clock_select_r ? oscillator_or_clock_input_pin
                                               : crystal_osc_tick;
  assign oscillator_enable = ~external_clock_select_r;

  // prescale terminal count: 0, 1, 3 or 7
  assign pre_last = 3'((4'h1 << prescale_r) - 4'h1);
  assign mod_en   = master_tick && (pre_cnt_r == pre_last);
  assign samp_en  = mod_en && (samp_cnt_r == `SAMPLE_DIV_LAST);

  // ratio is 32 shifted left by the field code
  assign ratio_full = `RATIO_BASE << decimation_ratio_field_r;
  assign rate_last  = RATIO_W'(ratio_full - 13'h0001);
  assign rate_en    = samp_en && (rate_cnt_r == rate_last);

  // prescale counter, restarted on a configuration write
  always_ff @(posedge ref_clk) begin
    if (rst || wr_cfg) begin
      pre_cnt_r <= 3'h0;
    end else if (master_tick) begin
      pre_cnt_r <= mod_en ? 3'h0 : pre_cnt_r + 3'h1;
    end
  end

  // divide by four toward the sampling clock
  always_ff @(posedge ref_clk) begin
    if (rst || wr_cfg) begin
      samp_cnt_r <= 2'h0;
    end else if (mod_en) begin
      samp_cnt_r <= samp_cnt_r + 2'h1;
    end
  end

  // decimation counter, one count per sample, shared by all channels
  always_ff @(posedge ref_clk) begin
    if (rst || wr_cfg) begin
      rate_cnt_r <= '0;
    end else if (samp_en) begin
      rate_cnt_r <= rate_en ? '0 : rate_cnt_r + RATIO_W'(1);
    end
  end

  // clock enable outputs, one cycle each
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_modulator_clock <= 1'b0;
      sampling_clock         <= 1'b0;
      output_rate_clock      <= 1'b0;
    end else begin
      analog_modulator_clock <= mod_en;
      sampling_clock         <= samp_en;
      output_rate_clock      <= rate_en;
    end
  end

  // capture every channel's raw word on the common rate tick
  for (genvar g = 0; g < CH; g++) begin : g_chan
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        raw_r[g] <= '0;
      end else if (output_rate_clock && state_r == ST_IDLE) begin
        raw_r[g] <= raw_data[g*CAL_W +: CAL_W];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        result_r[g] <= '0;
      end else if (state_r == ST_CALC && ch_r == 2'(g)) begin
        result_r[g] <= sat_val;
      end
    end

    assign result_data[g*CAL_W +: CAL_W] = result_r[g];
  end

  // gain factor is unity plus the signed gain word in units of 2^-23
  assign factor  = $signed({3'h1, {(CAL_W-1){1'b0}}})
                 + $signed({{2{mem_rd_data[CAL_W-1]}}, mem_rd_data});
  assign prod    = sum_r * factor;
  assign scaled  = prod >>> (CAL_W - 1);
  assign upper   = scaled[2*CAL_W+2:CAL_W-1];
  assign sat_hit = !((&upper) || (~|upper));
  assign sat_val = sat_hit ? {scaled[2*CAL_W+2], {(CAL_W-1){~scaled[2*CAL_W+2]}}}
                           : scaled[CAL_W-1:0];

  // sequencer walks channels: read offset, read gain, compute
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ch_r    <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          ch_r <= 2'h0;
          if (output_rate_clock) begin
            state_r <= ST_RD_OFF;
          end
        end
        ST_RD_OFF:  state_r <= ST_RD_GAIN;
        ST_RD_GAIN: state_r <= ST_CALC;
        ST_CALC: begin
          if (ch_r == 2'(CH - 1)) begin
            state_r <= ST_DONE;
          end else begin
            ch_r    <= ch_r + 2'h1;
            state_r <= ST_RD_OFF;
          end
        end
        ST_DONE:    state_r <= ST_IDLE;
        default:    state_r <= ST_IDLE;
      endcase
    end
  end

  // offset added once the offset word is out of the store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sum_r <= '0;
    end else if (state_r == ST_RD_GAIN) begin
      sum_r <= $signed({raw_r[ch_r][CAL_W-1], raw_r[ch_r]})
             + $signed({mem_rd_data[CAL_W-1], mem_rd_data});
    end
  end

  // single ready pulse once all channels hold new results
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_ready_pulse <= 1'b0;
    end else begin
      result_ready_pulse <= (state_r == ST_DONE);
    end
  end

  // store read port: sequencer first, bus reads only while idle
  assign apb_mem_rd  = access && !pwrite && is_cal && idx_ok && !mem_pend_r
                     && !pready_r && state_r == ST_IDLE && !output_rate_clock;
  assign mem_rd      = (state_r == ST_RD_OFF) || (state_r == ST_RD_GAIN) || apb_mem_rd;
  assign mem_rd_addr = (state_r == ST_RD_OFF)  ? {1'b0, ch_r} :
                       (state_r == ST_RD_GAIN) ? {1'b1, ch_r} :
                       {page[0], idx};

  cal_word_mem #(
    .WIDTH (CAL_W),
    .DEPTH (8),
    .AW    (3)
  ) u_cal (
    .ref_clk (ref_clk),
    .wr_en   (mem_wr),
    .wr_addr ({page[0], idx}),
    .wr_data (pwdata[CAL_W-1:0]),
    .rd_en   (mem_rd),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  // address decode
  assign access  = psel && penable;
  assign done    = access && pready_r;
  assign page    = paddr[AW-1:4];
  assign idx     = paddr[3:2];
  assign idx_ok  = (paddr[1:0] == 2'h0) && (idx < 2'(CH));
  assign is_cal  = (page == `OFS_CORR_PAGE) || (page == `GAIN_CORR_PAGE);
  assign is_res  = (page == `RESULT_PAGE);
  assign addr_ok = (paddr == `CFG_OFS) || (paddr == `STAT_OFS)
                || (paddr == `IRQ_EN_OFS) || (paddr == `IRQ_CLR_OFS)
                || (paddr == `DIV_STATE_OFS) || ((is_cal || is_res) && idx_ok);

  // writes take effect on the completing edge only
  assign wr_cfg = done && pwrite && (paddr == `CFG_OFS);
  assign wr_ien = done && pwrite && (paddr == `IRQ_EN_OFS);
  assign wr_clr = done && pwrite && (paddr == `IRQ_CLR_OFS);
  assign mem_wr = done && pwrite && is_cal && idx_ok;

  // configuration register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prescale_r               <= `PRE_RST;
      decimation_ratio_field_r <= `RATIO_RST;
      external_clock_select_r  <= `EXT_RST;
    end else if (wr_cfg) begin
      prescale_r               <= pwdata[`CFG_PRE_MSB:`CFG_PRE_LSB];
      decimation_ratio_field_r <= pwdata[`CFG_RATIO_MSB:`CFG_RATIO_LSB];
      external_clock_select_r  <= pwdata[`CFG_EXT_BIT];
    end
  end

  // interrupt enable register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en_r <= `IRQ_EN_RST;
    end else if (wr_ien) begin
      irq_en_r <= pwdata[1:0];
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  assign ev_set[`ST_READY_BIT] = (state_r == ST_DONE);
  assign ev_set[`ST_SAT_BIT]   = (state_r == ST_CALC) && sat_hit;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_r <= 2'h0;
    end else begin
      status_r <= (status_r & ~(wr_clr ? pwdata[1:0] : 2'h0)) | ev_set;
    end
  end

  assign irq = |(status_r & irq_en_r);

  // read data selection for non-store registers
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `CFG_OFS) begin
      rd_mux[`CFG_PRE_MSB:`CFG_PRE_LSB]     = prescale_r;
      rd_mux[`CFG_RATIO_MSB:`CFG_RATIO_LSB] = decimation_ratio_field_r;
      rd_mux[`CFG_EXT_BIT]                  = external_clock_select_r;
    end else if (paddr == `STAT_OFS) begin
      rd_mux[1:0] = status_r;
    end else if (paddr == `IRQ_EN_OFS) begin
      rd_mux[1:0] = irq_en_r;
    end else if (paddr == `DIV_STATE_OFS) begin
      rd_mux[RATIO_W+4:0] = {rate_cnt_r, samp_cnt_r, pre_cnt_r};
    end else if (is_res && idx_ok) begin
      rd_mux[CAL_W-1:0] = result_r[idx];
    end
  end

  // access phase: one wait state, more for a store read that must wait
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      mem_pend_r <= 1'b0;
    end else if (pready_r) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else if (access) begin
      if (!addr_ok) begin
        pready_r  <= 1'b1;
        pslverr_r <= 1'b1;
        prdata_r  <= 32'h0000_0000;
      end else if (pwrite || !is_cal) begin
        pready_r  <= 1'b1;
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (mem_pend_r) begin
        pready_r   <= 1'b1;
        mem_pend_r <= 1'b0;
        prdata_r   <= {{(32-CAL_W){1'b0}}, mem_rd_data};
      end else if (apb_mem_rd) begin
        mem_pend_r <= 1'b1;
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

endmodule : adc_clock_rate_divider

// [design/cal_word_mem.sv]
`timescale 1ns/1ps
// calibration word store, one write port and one registered read port
module cal_word_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data held in a register until the next read
  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : cal_word_mem

// [test/adc_clock_rate_divider_checker.sv]
`timescale 1ns/1ps
// watches the divider chain, interrupt line and bus answers at the top ports
module adc_clock_rate_divider_checker #(
  parameter int AW = 12
) (
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          crystal_osc_tick,
  input wire logic          oscillator_or_clock_input_pin,
  input wire logic          oscillator_enable,
  input wire logic          analog_modulator_clock,
  input wire logic          sampling_clock,
  input wire logic          output_rate_clock,
  input wire logic          result_ready_pulse,
  input wire logic          irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a result pulse lands eleven cycles after the rate pulse and lasts one cycle
  sequence ready_follows;
    ##11 result_ready_pulse ##1 !result_ready_pulse;
  endsequence
  // setup cycle then first access cycle of a bus transfer
  sequence bus_start;
    (psel && !penable) ##1 (psel && penable);
  endsequence

  src_select_a: assert property (analog_modulator_clock |->
    $past(oscillator_enable ? crystal_osc_tick : oscillator_or_clock_input_pin))
    else $error("modulator pulse without a tick from the selected source");
  samp_on_mod_a: assert property (sampling_clock |-> analog_modulator_clock)
    else $error("sampling pulse off a modulator pulse");
  rate_on_samp_a: assert property (output_rate_clock |-> sampling_clock)
    else $error("rate pulse off a sampling pulse");
  ready_after_a: assert property (output_rate_clock |-> ready_follows)
    else $error("result pulse missing after rate pulse");
  ready_cause_a: assert property (result_ready_pulse |-> $past(output_rate_clock, 11))
    else $error("result pulse without a rate pulse");
  rst_defaults_a: assert property (disable iff (1'b0) rst |=>
    !oscillator_enable && !irq && !result_ready_pulse)
    else $error("outputs wrong after reset");
  src_stable_a: assert property (!$stable(oscillator_enable) |->
    $past(psel && penable && pready && pwrite && paddr == '0) || $past(rst))
    else $error("source select moved without a config write");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  bus_answer_a: assert property (bus_start |-> !pready ##[1:16] pready)
    else $error("bus answer out of time");
  irq_fall_a: assert property ($fell(irq) |-> $past(pready && pwrite))
    else $error("interrupt dropped without a write");
endmodule : adc_clock_rate_divider_checker

bind adc_clock_rate_divider adc_clock_rate_divider_checker #(.AW(AW)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .crystal_osc_tick(crystal_osc_tick),
  .oscillator_or_clock_input_pin(oscillator_or_clock_input_pin),
  .oscillator_enable(oscillator_enable), .analog_modulator_clock(analog_modulator_clock),
  .sampling_clock(sampling_clock), .output_rate_clock(output_rate_clock),
  .result_ready_pulse(result_ready_pulse), .irq(irq));

// [test/adc_clock_rate_divider_tb_top.sv]
`timescale 1ns/1ps
`include "adc_clk_regs.svh"
// rate chain, register, interrupt and correction traffic with a seeded mix
module adc_clock_rate_divider_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [71:0] raw_data = 72'h0, result_data;
  logic        pready, pslverr, e, xtal, pin, osc_en, amc, samp, orc, rrp, irq;
  logic [23:0] rv [3], ov [3], gv [3];
  int          mismatches = 0, total_checks = 0, seed = 32'h556d;

  always #2.5 ref_clk = ~ref_clk;

  adc_clock_rate_divider i_adc_clock_rate_divider (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .crystal_osc_tick(xtal), .oscillator_or_clock_input_pin(pin), .oscillator_enable(osc_en),
    .raw_data(raw_data), .analog_modulator_clock(amc), .sampling_clock(samp),
    .output_rate_clock(orc), .result_ready_pulse(rrp), .result_data(result_data), .irq(irq));

  master_clock_source i_master_clock_source (.ref_clk(ref_clk), .oscillator_enable(osc_en),
    .crystal_osc_tick(xtal), .oscillator_or_clock_input_pin(pin));

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task give_up;
    mismatches++;
    summarize();
  endtask : give_up

  // one bus transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) give_up();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_pulse(input logic rate);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((rate ? orc : rrp) !== 1'b1 && n < 20000);
    if ((rate ? orc : rrp) !== 1'b1) give_up();
  endtask : wait_pulse

  // counts ticks and pulses over one full output rate period
  task measure(input logic [1:0] p, input logic [2:0] c, input logic x);
    int n, t, m, s;
    apb(1'b1, `CFG_OFS, {26'h0, x, c, p});
    wait_pulse(1'b1);
    n = 0;
    t = 0;
    m = 0;
    s = 0;
    do begin
      @(posedge ref_clk);
      n++;
      t += int'(x ? pin : xtal);
      m += int'(amc);
      s += int'(samp);
    end while (orc !== 1'b1 && n < 20000);
    if (orc !== 1'b1) give_up();
    chk(32'(t), 32'((128 << c) << p));
    chk(32'(m), 32'(128 << c));
    chk(32'(s), 32'(32 << c));
  endtask : measure

  function automatic logic [23:0] sx(input logic [31:0] v);
    return {{4{v[20]}}, v[19:0]};
  endfunction : sx

  // offset then gain, saturated to 24 bits
  function automatic logic [23:0] corr(input logic [23:0] r, o, g);
    longint s;
    s = longint'($signed(r)) + longint'($signed(o));
    s = (s * (64'sh800000 + longint'($signed(g)))) >>> 23;
    if (s > 64'sh7fffff) s = 64'sh7fffff;
    if (s < -64'sh800000) s = -64'sh800000;
    return s[23:0];
  endfunction : corr

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, `CFG_OFS, 32'h0);
    chk(q, 32'h0000_002c);
    chk({31'h0, osc_en}, 32'h0);
    apb(1'b0, `IRQ_EN_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    measure(2'h0, 3'h3, 1'b1);
    for (int p = 3; p >= 0; p--) measure(2'(p), 3'h0, 1'b0);
    // corner saturation first, then independent random words per channel
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 3; c++) begin
        rv[c] = (r == 0) ? 24'h7fffff : sx($random(seed));
        ov[c] = (r == 0) ? 24'h7fffff : sx($random(seed));
        gv[c] = (r == 0) ? 24'h000000 : sx($random(seed));
        apb(1'b1, 12'h020 + 12'(4 * c), {8'h0, ov[c]});
        apb(1'b1, 12'h030 + 12'(4 * c), {8'h0, gv[c]});
        raw_data[c*24 +: 24] <= rv[c];
      end
      wait_pulse(1'b0);
      wait_pulse(1'b0);
      // result port, result registers and stored words read back per channel
      for (int c = 0; c < 3; c++) begin
        chk({8'h0, result_data[c*24 +: 24]}, {8'h0, corr(rv[c], ov[c], gv[c])});
        apb(1'b0, 12'h040 + 12'(4 * c), 32'h0);
        chk(q, {8'h0, corr(rv[c], ov[c], gv[c])});
        apb(1'b0, 12'h020 + 12'(4 * c), 32'h0);
        chk(q, {8'h0, ov[c]});
        apb(1'b0, 12'h030 + 12'(4 * c), 32'h0);
        chk(q, {8'h0, gv[c]});
      end
    end
    // enabled interrupt rises on a result and falls on clear; masked one stays low
    for (int k = 1; k >= 0; k--) begin
      apb(1'b1, `IRQ_EN_OFS, 32'(k));
      wait_pulse(1'b0);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'(k));
      apb(1'b0, `STAT_OFS, 32'h0);
      chk({30'h0, q[1:0]}, 32'h3);
      apb(1'b1, `IRQ_CLR_OFS, 32'h1);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
    end
    for (int c = 0; c < 8; c++) measure(2'h0, 3'(c), 1'b0);
    summarize();
  end
endmodule : adc_clock_rate_divider_tb_top

// [test/master_clock_source.sv]
`timescale 1ns/1ps
// crystal ticks only while enabled; the clock input pin ticks every PIN_DIV cycles
module master_clock_source #(
  parameter int PIN_DIV = 3
) (
  input  wire logic ref_clk,
  input  wire logic oscillator_enable,
  output logic      crystal_osc_tick = 1'b0,
  output logic      oscillator_or_clock_input_pin = 1'b0
);
  int pin_cnt = 0;
  // crystal stands still when the external input path is selected
  always @(posedge ref_clk) crystal_osc_tick <= oscillator_enable;
  // external source runs whatever the selection
  always @(posedge ref_clk) begin
    pin_cnt <= (pin_cnt == PIN_DIV - 1) ? 0 : pin_cnt + 1;
    oscillator_or_clock_input_pin <= (pin_cnt == 0);
  end
endmodule : master_clock_source
